// *** rtl/flash_array.v ***
// byte-wide flash array model with single-cycle read and program/erase ports
// assumes the controller issues at most one operation per cycle and waits for it to time out
`timescale 1ns/1ps
`include "flash_ctrl_map.vh"

module flash_array (
    // clock and reset
    input wire mclk,
    input wire resetn,
    input wire clk_en,
    // access
    input wire [15:0] addr,
    input wire prog,
    input wire erase_page,
    input wire erase_all,
    input wire [7:0] wdata,
    output reg [7:0] rdata,
    // protection key byte, always visible
    output wire [7:0] key_byte
);

    // cells are unknown until the first erase-all; run one before any other command
    reg [7:0] mem [0:63487];
    // key byte is nonvolatile: blank at power-up, untouched by reset, so a stored key survives it
    reg [7:0] key_q = 8'hff;
    integer i;

    assign key_byte = key_q;

    always @(posedge mclk) begin
        if (clk_en) begin
            rdata <= mem[addr];
            if (erase_all) begin
                for (i = 0; i < 63488; i = i + 1) begin
                    mem[i] <= 8'hff;
                end
            end else if (erase_page) begin
                for (i = 0; i < 512; i = i + 1) begin
                    mem[{addr[15:`PAGE_OFFSET_BITS], 9'h000} + i[8:0]] <= 8'hff;
                end
            end else if (prog) begin
                // programming only clears bits, as real flash cells do
                mem[addr] <= mem[addr] & wdata;
            end
        end
    end

    // no key change while the core is held in reset
    always @(posedge mclk) begin
        if (clk_en && resetn) begin
            if (erase_all) begin
                key_q <= 8'hff;
            end else if (prog && addr == `PROT_KEY_ADDR) begin
                key_q <= key_q & wdata;
            end
        end
    end

endmodule // flash_array

// *** rtl/flash_command_controller.v ***
// flash command controller: sfr register file, unlock check, command sequencer, core stall
// assumes a core that writes sfrs with sfr_wr and reads one cycle later via registered sfr_rdata
//
// Operation
// - writing a command code to the sfr at 0xb9 launches the operation.
// - a command runs only when the unlock register holds 0x3b.
// - unlock register returns to 0xff when an operation completes.
// - core held on the command write until the operation finishes.
// - interrupts stay pending during an operation, serviced afterwards.
// - peripherals keep running; only the core is stalled.
// - code 1 programs the data byte at the pointer address; target pre-erased.
// - code 2 erases the 512-byte page holding the pointer address.
// - code 3 erases the whole array; not for user code.
// - code 4 reads the pointer address byte into the data register.
// - code 8 programs one protection byte.
// - protection changes allowed only when protection key matches stored key.
// - stored key 0xff skips the key comparison.
// - stored key programmed by command 8; only once.
// - read byte can return the protection bytes of page 123.
// - write byte is refused in the protection area.
// - data and pointer registers are 8 bits, zero at reset.
// - protect command uses only the low pointer byte.
// - protection key register cleared on every protect command.
// - new key and protection settings act only after reset.
`timescale 1ns/1ps
`include "flash_ctrl_map.vh"

module flash_command_controller (
    // clock and reset
    input wire mclk,
    input wire resetn,
    input wire clk_en,
    // sfr bus from the core
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // core control
    output reg core_hold,
    output reg irq_defer,
    // protection status held since reset
    output reg prot_key_active
);

    // ************************************************
    // states
    // ************************************************
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ST_DONE = 2'b11;

    reg [1:0] state_q, state_d;
    reg [7:0] command_q;
    reg [7:0] unlock_q;
    reg [7:0] protkey_q;
    reg [7:0] data_q;
    reg [7:0] addr_lo_q;
    reg [7:0] addr_hi_q;
    reg [15:0] op_addr_q;
    reg [7:0] op_cmd_q;
    reg [15:0] wait_q;
    reg [7:0] latched_key_q;
    reg key_latched_q;
    reg prog_q, erase_page_q, erase_all_q;

    wire [7:0] array_rdata;
    wire [7:0] array_key;

    wire cmd_write = sfr_wr && (sfr_addr == `OFF_FLASH_COMMAND);
    wire unlocked = (unlock_q == `UNLOCK_KEY_VALUE);
    wire [15:0] ptr_addr = {addr_hi_q, addr_lo_q};
    wire [15:0] prot_addr = {`PROT_ADDR_HIGH, addr_lo_q};
    wire in_prot_area = (ptr_addr >= `PROT_AREA_BASE) && (ptr_addr <= `FLASH_LAST_ADDR);
    wire prot_addr_ok = (prot_addr >= `PROT_AREA_BASE);
    // key latched at reset release, so later key programming waits for next reset
    wire key_ok = !prot_key_active || (protkey_q == latched_key_q);
    // once a key is stored the key byte itself is frozen until an erase-all blanks it
    wire key_byte_free = (array_key == `PROT_KEY_BLANK);

    localparam integer PROG_N = `PROG_CYCLES;
    localparam integer ERASE_N = `ERASE_CYCLES;
    localparam [15:0] PROG_WAIT = PROG_N[15:0];
    localparam [15:0] ERASE_WAIT = ERASE_N[15:0];

    flash_array u_array (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .addr(op_addr_q),
        .prog(prog_q),
        .erase_page(erase_page_q),
        .erase_all(erase_all_q),
        .wdata(data_q),
        .rdata(array_rdata),
        .key_byte(array_key)
    );

    // ************************************************
    // strap-like catch of the stored key after reset
    // ************************************************
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            key_latched_q <= 1'b0;
            latched_key_q <= 8'hff;
            prot_key_active <= 1'b0;
        end else if (clk_en && !key_latched_q) begin
            key_latched_q <= 1'b1;
            latched_key_q <= array_key;
            prot_key_active <= (array_key != `PROT_KEY_BLANK);
        end
    end

    // ************************************************
    // sequencer
    // ************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_write && unlocked) begin
                    state_d = ST_WAIT;
                end
            end
            ST_READ: state_d = ST_DONE;
            ST_WAIT: begin
                if (wait_q == 16'h0000) begin
                    state_d = (op_cmd_q == `CMD_READ_BYTE) ? ST_READ : ST_DONE;
                end
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            command_q <= `RST_FLASH_COMMAND;
            unlock_q <= `RST_FLASH_UNLOCK_KEY;
            protkey_q <= `RST_PROTECTION_KEY;
            data_q <= `RST_FLASH_DATA_BYTE;
            addr_lo_q <= `RST_FLASH_ADDR;
            addr_hi_q <= `RST_FLASH_ADDR;
            op_addr_q <= 16'h0000;
            op_cmd_q <= 8'h00;
            wait_q <= 16'h0000;
            prog_q <= 1'b0;
            erase_page_q <= 1'b0;
            erase_all_q <= 1'b0;
            core_hold <= 1'b0;
            irq_defer <= 1'b0;
            sfr_rdata <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            prog_q <= 1'b0;
            erase_page_q <= 1'b0;
            erase_all_q <= 1'b0;
            // plain register writes are only accepted while idle; the core is held otherwise
            if (sfr_wr && state_q == ST_IDLE) begin
                case (sfr_addr)
                    `OFF_FLASH_COMMAND: command_q <= sfr_wdata;
                    `OFF_FLASH_UNLOCK_KEY: unlock_q <= sfr_wdata;
                    `OFF_PROTECTION_KEY: protkey_q <= sfr_wdata;
                    `OFF_FLASH_DATA_BYTE: data_q <= sfr_wdata;
                    `OFF_FLASH_ADDR_LOW: addr_lo_q <= sfr_wdata;
                    `OFF_FLASH_ADDR_HIGH: addr_hi_q <= sfr_wdata;
                    default: ;
                endcase
            end
            if (state_q == ST_IDLE && cmd_write) begin
                op_cmd_q <= sfr_wdata;
                op_addr_q <= ptr_addr;
                if (unlocked) begin
                    core_hold <= 1'b1;
                    irq_defer <= 1'b1;
                    wait_q <= 16'h0001;
                    case (sfr_wdata)
                        `CMD_WRITE_BYTE: begin
                            if (!in_prot_area) begin
                                prog_q <= 1'b1;
                                wait_q <= PROG_WAIT;
                            end
                        end
                        `CMD_ERASE_PAGE: begin
                            erase_page_q <= 1'b1;
                            wait_q <= ERASE_WAIT;
                        end
                        `CMD_ERASE_ALL: begin
                            erase_all_q <= 1'b1;
                            wait_q <= ERASE_WAIT;
                        end
                        `CMD_READ_BYTE: wait_q <= 16'h0000;
                        `CMD_PROTECT: begin
                            op_addr_q <= prot_addr;
                            protkey_q <= 8'h00;
                            if (prot_addr_ok && key_ok && (prot_addr != `PROT_KEY_ADDR || key_byte_free)) begin
                                prog_q <= 1'b1;
                                wait_q <= PROG_WAIT;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            if (state_q == ST_WAIT && wait_q != 16'h0000) begin
                wait_q <= wait_q - 16'h0001;
            end
            if (state_q == ST_READ) begin
                data_q <= array_rdata;
            end
            if (state_q == ST_DONE) begin
                unlock_q <= `RST_FLASH_UNLOCK_KEY;
                core_hold <= 1'b0;
                irq_defer <= 1'b0;
            end
            case (sfr_addr)
                `OFF_FLASH_COMMAND: sfr_rdata <= command_q;
                `OFF_FLASH_UNLOCK_KEY: sfr_rdata <= unlock_q;
                `OFF_PROTECTION_KEY: sfr_rdata <= protkey_q;
                `OFF_FLASH_DATA_BYTE: sfr_rdata <= data_q;
                `OFF_FLASH_ADDR_LOW: sfr_rdata <= addr_lo_q;
                `OFF_FLASH_ADDR_HIGH: sfr_rdata <= addr_hi_q;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule // flash_command_controller

// *** rtl/flash_ctrl_map.vh ***
// register offsets, command codes, keys and timing counts for the flash command controller
// assumes the includer works on an 8-bit sfr bus and a 16-bit byte-wide flash array
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// ************************************************
// register offsets
// ************************************************
`define OFF_FLASH_COMMAND 8'hb9
`define OFF_FLASH_UNLOCK_KEY 8'hba
`define OFF_PROTECTION_KEY 8'hbb
`define OFF_FLASH_DATA_BYTE 8'hbc
`define OFF_FLASH_ADDR_LOW 8'hc6
`define OFF_FLASH_ADDR_HIGH 8'hc7

// ************************************************
// reset values and keys
// ************************************************
`define RST_FLASH_COMMAND 8'h00
`define RST_FLASH_UNLOCK_KEY 8'hff
`define RST_PROTECTION_KEY 8'hff
`define RST_FLASH_DATA_BYTE 8'h00
`define RST_FLASH_ADDR 8'h00
`define UNLOCK_KEY_VALUE 8'h3b
`define PROT_KEY_BLANK 8'hff
`define PROT_KEY_ADDR 16'hf7eb
`define PROT_AREA_BASE 16'hf7eb
`define PROT_ADDR_HIGH 8'hf7

// ************************************************
// command codes
// ************************************************
`define CMD_WRITE_BYTE 8'h01
`define CMD_ERASE_PAGE 8'h02
`define CMD_ERASE_ALL 8'h03
`define CMD_READ_BYTE 8'h04
`define CMD_PROTECT 8'h08

// ************************************************
// array geometry and timing
// ************************************************
`define PAGE_OFFSET_BITS 9
`define FLASH_LAST_ADDR 16'hf7ff
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 1000
`define ERASE_TIME_NS 2000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/unused_placeholder_none.v ***
// holds no module: the controller needs only the array beside it

// *** test/core_model.sv ***
// processor core stand-in: program counter and pending interrupt
// assumes core_hold and irq_defer come from the flash controller
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // controller side
    input wire core_hold,
    input wire irq_defer,
    input wire irq_req,
    // observation
    output reg [15:0] pc_q,
    output reg [7:0] taken_q
);
reg pend_q;
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        pc_q <= 16'h0000;
        taken_q <= 8'h00;
        pend_q <= 1'b0;
    end else begin
        if (!core_hold) pc_q <= pc_q + 16'h0001;
        if (pend_q && !irq_defer) begin
            taken_q <= taken_q + 8'h01;
            pend_q <= 1'b0;
        end else if (irq_req) pend_q <= 1'b1;
    end
end
endmodule // core_model

// *** test/flash_command_controller_bench.sv ***
// self-checking bench for the flash command controller
// assumes the core stand-in and the port checker compile alongside
`timescale 1ns/1ps
module flash_command_controller_bench;
reg mclk = 1'b0;
reg resetn = 1'b0;
reg [7:0] sfr_addr = 8'h00;
reg sfr_wr = 1'b0;
reg clk_en = 1'b1;
reg [7:0] sfr_wdata = 8'h00;
reg irq_req = 1'b0;
reg rd_s = 1'b0;
reg rd_d = 1'b0;
wire [7:0] sfr_rdata;
wire core_hold, irq_defer, prot_key_active;
wire [15:0] pc_q;
wire [7:0] taken_q;
reg [7:0] exp_q[$];
reg [31:0] seed = 32'd52885;
reg [7:0] hi, lo, d, t, c;
reg [15:0] p;
integer failures = 0;
integer n_tests = 0;
integer n;
always #5 mclk = ~mclk;
flash_command_controller dut_u (.mclk, .resetn, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
    .core_hold, .irq_defer, .prot_key_active);
core_model core_u (.mclk, .resetn, .core_hold, .irq_defer, .irq_req, .pc_q, .taken_q);
function [31:0] xs(input [31:0] s);
    reg [31:0] v;
    begin
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    end
endfunction
task chk(input [7:0] seen, input [7:0] want);
    begin
        n_tests = n_tests + 1;
        if (seen !== want) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    end
endtask
task results;
    begin
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
task wr(input [7:0] a, input [7:0] v);
    begin
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
        // idle edge, so back-to-back calls never drive the strobe twice in one step
        @(negedge mclk);
    end
endtask
// ********
// readback: note goes in at the request, compare when the data lands
// ********
task rd(input [7:0] a, input [7:0] v);
    begin
        sfr_addr = a;
        exp_q.push_back(v);
        rd_s = 1'b1;
        @(negedge mclk);
        rd_s = 1'b0;
        @(negedge mclk);
    end
endtask
always @(posedge mclk) rd_d <= rd_s;
always @(negedge mclk) if (rd_d) chk(sfr_rdata, exp_q.pop_front());
task cmd(input [7:0] k);
    begin
        wr(8'hba, 8'h3b);
        wr(8'hb9, k);
        n = 0;
        p = pc_q;
        t = taken_q;
        irq_req = 1'b1;
        @(negedge mclk);
        irq_req = 1'b0;
        while (core_hold === 1'b1 && n < 400) begin
            @(negedge mclk);
            n = n + 1;
        end
        chk(n > 0 && n < 400, 8'h01);
        chk(pc_q[7:0], p[7:0]);
        chk(taken_q, t);
        @(negedge mclk);
        chk(taken_q, t + 8'h01);
    end
endtask
initial begin
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    rd(8'hb9, 8'h00);
    rd(8'hba, 8'hff);
    rd(8'hbb, 8'hff);
    rd(8'hbc, 8'h00);
    rd(8'hc6, 8'h00);
    rd(8'hc7, 8'h00);
    rd(8'hc0, 8'h00);
    clk_en = 1'b0;
    wr(8'hbc, 8'h5a);
    clk_en = 1'b1;
    rd(8'hbc, 8'h00);
    $display("register reset values done");
    cmd(8'h03);
    seed = xs(seed);
    hi = seed[7:0] & 8'h7e;
    lo = seed[15:8];
    d = {1'b0, seed[22:17], 1'b1};
    wr(8'hc7, hi);
    wr(8'hc6, lo);
    cmd(8'h04);
    rd(8'hbc, 8'hff);
    rd(8'hba, 8'hff);
    wr(8'hbc, d);
    cmd(8'h01);
    wr(8'hbc, 8'h00);
    wr(8'hb9, 8'h01);
    rd(8'hb9, 8'h01);
    for (c = 8'h05; c < 8'h08; c = c + 8'h01) cmd(c);
    rd(8'hbc, 8'h00);
    cmd(8'h04);
    rd(8'hbc, d);
    $display("write and read done");
    wr(8'hc7, hi + 8'h02);
    cmd(8'h01);
    wr(8'hc7, hi | 8'h01);
    wr(8'hc6, ~lo);
    cmd(8'h02);
    wr(8'hc7, hi);
    wr(8'hc6, lo);
    cmd(8'h04);
    rd(8'hbc, 8'hff);
    wr(8'hc7, hi + 8'h02);
    cmd(8'h04);
    rd(8'hbc, d);
    $display("page erase done");
    wr(8'hc7, 8'hf7);
    wr(8'hc6, 8'hf0);
    wr(8'hbc, 8'h00);
    cmd(8'h01);
    cmd(8'h04);
    rd(8'hbc, 8'hff);
    wr(8'hbc, 8'hfe);
    wr(8'hc7, 8'h00);
    wr(8'hbb, 8'h55);
    cmd(8'h08);
    rd(8'hbb, 8'h00);
    wr(8'hc7, 8'hf7);
    cmd(8'h04);
    rd(8'hbc, 8'hfe);
    wr(8'hc6, 8'heb);
    wr(8'hbc, d);
    cmd(8'h08);
    chk(prot_key_active, 8'h00);
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    chk(prot_key_active, 8'h01);
    wr(8'hbb, ~d);
    wr(8'hc6, 8'hf1);
    wr(8'hbc, 8'h00);
    cmd(8'h08);
    wr(8'hc7, 8'hf7);
    cmd(8'h04);
    rd(8'hbc, 8'hff);
    wr(8'hbb, d);
    wr(8'hbc, 8'h7f);
    cmd(8'h08);
    cmd(8'h04);
    rd(8'hbc, 8'h7f);
    wr(8'hbb, d);
    wr(8'hc6, 8'heb);
    wr(8'hbc, 8'h00);
    cmd(8'h08);
    cmd(8'h04);
    rd(8'hbc, d);
    $display("protection done");
    repeat (2) @(negedge mclk);
    results;
end
initial begin
    repeat (20000) @(posedge mclk);
    failures = failures + 1;
    results;
end
endmodule // flash_command_controller_bench
bind flash_command_controller flash_ctrl_props chk_u (.mclk, .resetn, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .core_hold, .irq_defer, .prot_key_active);

// *** test/flash_ctrl_props.sv ***
// port checker for the flash command controller
// assumes clk_en only drops while no command runs
`timescale 1ns/1ps
module flash_ctrl_props (
    // clock and reset
    input wire mclk,
    input wire resetn,
    input wire clk_en,
    // sfr bus
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    // core control
    input wire core_hold,
    input wire irq_defer,
    input wire prot_key_active
);
// ********
// unlock key shadow
// ********
reg [7:0] key_q;
reg [7:0] cmd_q;
reg hold_q;
// the key clears on the edge the hold drops, one sample before hold_q sees it
wire [7:0] key_e = (hold_q && !core_hold) ? 8'hff : key_q;
wire idle_wr = sfr_wr && clk_en && !core_hold;
wire go = idle_wr && sfr_addr == 8'hb9 && key_e == 8'h3b;
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        key_q <= 8'hff;
        cmd_q <= 8'h00;
        hold_q <= 1'b0;
    end else begin
        hold_q <= core_hold;
        key_q <= (idle_wr && sfr_addr == 8'hba) ? sfr_wdata : key_e;
        if (go) cmd_q <= sfr_wdata;
    end
end
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
AST_DEFER: assert property (irq_defer == core_hold) else $error("defer differs from hold");
AST_LAUNCH: assert property (go |=> core_hold) else $error("command did not start");
AST_LOCKED: assert property (idle_wr && sfr_addr == 8'hb9 && key_e != 8'h3b |=> !core_hold)
    else $error("locked command ran");
AST_KEY_RD: assert property (sfr_addr == 8'hba && !sfr_wr && !core_hold && !hold_q |=> sfr_rdata == $past(key_e))
    else $error("unlock key readback wrong");
AST_READ_LEN: assert property ($rose(core_hold) && cmd_q == 8'h04 |-> core_hold[*3] ##1 !core_hold)
    else $error("read hold length wrong");
AST_RSVD_LEN: assert property ($rose(core_hold) && cmd_q > 8'h04 && cmd_q < 8'h08 |-> core_hold[*3] ##1 !core_hold)
    else $error("reserved code hold wrong");
AST_ERASE_END: assert property ($rose(core_hold) && (cmd_q == 8'h02 || cmd_q == 8'h03)
    |-> core_hold[*8] ##[1:260] !core_hold) else $error("erase length wrong");
AST_PROG_END: assert property ($rose(core_hold) && (cmd_q == 8'h01 || cmd_q == 8'h08) |-> ##[1:150] !core_hold)
    else $error("program did not end");
AST_KEY_ACT: assert property (resetn[*3] |-> $stable(prot_key_active)) else $error("key flag moved");
cover property ($rose(core_hold) && cmd_q == 8'h04);
cover property ($rose(core_hold) && cmd_q == 8'h08);
cover property (idle_wr && sfr_addr == 8'hb9 && key_e != 8'h3b);
endmodule // flash_ctrl_props
